//--- hw/sfr_pkg.sv
// package with offsets, reset values and types of the special function register map
package sfr_pkg;
    // ********************************************************
    // widths
    // ********************************************************
    localparam int DATA_W = 8; // register width
    localparam int IDX_W = 8; // register index: bank bit plus seven offset bits
    localparam int PC_W = 13; // full program counter
    localparam int LATCH_W = 5; // upper program counter holding bits
    localparam int PORT_A_W = 5; // implemented port a bits
    localparam int WB_ADR_W = 10; // byte address, four times the index
    localparam int WB_DAT_W = 32; // wishbone data width
    localparam int RST_SRC_N = 5; // reset source pins

    // ********************************************************
    // register indices
    // ********************************************************
    localparam logic [6:0] IDX_IND_ACCESS = 7'h00; // indirect access, no storage
    localparam logic [6:0] IDX_TMR = 7'h01; // timer count
    localparam logic [6:0] IDX_PC_LOW = 7'h02; // program counter low
    localparam logic [6:0] IDX_STATUS = 7'h03; // core status
    localparam logic [6:0] IDX_POINTER = 7'h04; // indirect pointer
    localparam logic [6:0] IDX_PORT_A = 7'h05; // port a
    localparam logic [6:0] IDX_PORT_B = 7'h06; // port b
    localparam logic [6:0] IDX_PC_LATCH = 7'h0a; // program counter high latch
    localparam logic [6:0] IDX_INT_CTRL = 7'h0b; // interrupt control
    localparam logic [6:0] IDX_PIR = 7'h0c; // peripheral interrupt flags
    localparam logic [6:0] IDX_CONV_RES = 7'h1e; // conversion result
    localparam logic [6:0] IDX_CONV = 7'h1f; // converter control
    localparam logic [7:0] IDX_PWR_CTRL = 8'h8e; // power control, bank 1 only

    // ********************************************************
    // field positions
    // ********************************************************
    localparam int ST_TO = 4; // time-out flag
    localparam int ST_PD = 3; // power-down flag
    localparam int CONV_GO = 2; // conversion running
    localparam int CONV_GP = 5; // bit 5 of converter control
    localparam int PIR_CONV = 6; // conversion done flag
    localparam int PWR_PARITY = 2; // parity error cause, low when it happened
    localparam int PWR_POWER_ON = 1; // power-on cause, low when it happened
    localparam int PWR_BROWN_OUT = 0; // brown-out cause, low when it happened

    // ********************************************************
    // reset values and masks
    // ********************************************************
    localparam logic [7:0] RV_ZERO = 8'h00; // zero for all-zero registers and unknown bits
    localparam logic [7:0] RV_STATUS = 8'h18; // power-up core status
    localparam logic [7:0] RV_PWR_CTRL = 8'h07; // power-up power control, bits 6:3 absent and read zero
    localparam logic [7:0] WM_STATUS = 8'he7; // software writable status bits
    localparam logic [7:0] KEEP_INT_CTRL = 8'h01; // interrupt control bit kept on other resets
    localparam logic [7:0] KEEP_STATUS = 8'h07; // status bits kept on other resets
    localparam logic [7:0] IMPL_CONV = 8'hfd; // implemented converter control bits
    localparam logic [7:0] WM_PWR_CTRL = 8'h07; // software writable power control bits

    // ********************************************************
    // reset classes
    // ********************************************************
    localparam int SRC_POR = 0; // power-on pin
    localparam int SRC_BROWN = 1; // brown-out pin
    localparam int SRC_PARITY = 2; // parity error pin
    localparam int SRC_CLEAR_N = 3; // master clear pin, active low
    localparam int SRC_WDT = 4; // watchdog pin
    typedef enum logic [1:0] {
        RC_NONE = 2'b00,
        RC_OTHER = 2'b01,
        RC_POWER = 2'b11
    } sfr_reset_class_t;
endpackage : sfr_pkg

//--- hw/sfr_access_if.sv
// interface between the bus slave and the register bank
`timescale 1ns/100ps
interface sfr_access_if;
    import sfr_pkg::*;
    logic wr_stb; // write takes effect at this edge
    logic [IDX_W-1:0] idx; // register index
    logic [DATA_W-1:0] wdata; // write data
    logic [DATA_W-1:0] rdata; // read data of the indexed register
    modport bus_side (output wr_stb, output idx, output wdata, input rdata);
    modport reg_side (input wr_stb, input idx, input wdata, output rdata);
endinterface : sfr_access_if

//--- hw/sfr_wb_slave.sv
// classic wishbone slave that answers every access one cycle after the request
`timescale 1ns/100ps
module sfr_wb_slave
    import sfr_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic cyc_in,
    input wire logic stb_in,
    input wire logic we_in,
    input wire logic [WB_ADR_W-1:0] adr_in,
    input wire logic [3:0] sel_in,
    input wire logic [WB_DAT_W-1:0] dat_in,
    output logic [WB_DAT_W-1:0] dat_out,
    output logic ack_out,
    sfr_access_if.bus_side acc
);
    // ********************************************************
    // decode
    // ********************************************************
    logic ack_q; // answer flag
    logic [WB_DAT_W-1:0] dat_q; // captured read data
    wire req = cyc_in & stb_in; // request present
    wire ack_d = req & ~ack_q; // answer once, then drop for a cycle
    // writes land on the edge where the master sees ack, so held data is final
    assign acc.wr_stb = req & we_in & ack_q & sel_in[0];
    assign acc.idx = adr_in[WB_ADR_W-1:2];
    assign acc.wdata = dat_in[DATA_W-1:0];
    assign ack_out = ack_q;
    assign dat_out = dat_q;

    // ack and read data register
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= ack_d;
            // upper bytes always read zero
            dat_q <= ack_d ? {{(WB_DAT_W-DATA_W){1'b0}}, acc.rdata} : '0;
        end
    end
endmodule : sfr_wb_slave

//--- hw/sfr_reset_class.sv
// synchronises the reset source pins and sorts them into reset classes
`timescale 1ns/100ps
module sfr_reset_class
    import sfr_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [RST_SRC_N-1:0] src_in,
    output sfr_reset_class_t class_out,
    output logic [RST_SRC_N-1:0] src_out
);
    // ********************************************************
    // two-stage synchronisers
    // ********************************************************
    logic [RST_SRC_N-1:0] s1_q; // first stage, read only by the second
    logic [RST_SRC_N-1:0] s2_q; // second stage, safe to decode
    sfr_reset_class_t class_q; // registered class
    logic [RST_SRC_N-1:0] src_q; // registered sources, master clear made active high

    genvar g;
    generate
        for (g = 0; g < RST_SRC_N; g++) begin : g_sync
            // master clear rests high, the others rest low
            always_ff @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    s1_q[g] <= (g == SRC_CLEAR_N);
                    s2_q[g] <= (g == SRC_CLEAR_N);
                end else begin
                    s1_q[g] <= src_in[g];
                    s2_q[g] <= s1_q[g];
                end
            end
        end
    endgenerate

    // ********************************************************
    // class decode
    // ********************************************************
    wire pwr = s2_q[SRC_POR] | s2_q[SRC_BROWN] | s2_q[SRC_PARITY]; // power-up class
    wire oth = ~s2_q[SRC_CLEAR_N] | s2_q[SRC_WDT]; // other class
    wire [RST_SRC_N-1:0] src_d = {s2_q[SRC_WDT], ~s2_q[SRC_CLEAR_N], s2_q[2:0]};
    wire sfr_reset_class_t class_d = pwr ? RC_POWER : (oth ? RC_OTHER : RC_NONE);

    // power-up class wins when both are present
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            class_q <= RC_NONE;
            src_q <= '0;
        end else begin
            class_q <= class_d;
            src_q <= src_d;
        end
    end
    assign class_out = class_q;
    assign src_out = src_q;
endmodule : sfr_reset_class

//--- hw/sfr_map.sv
// special function register bank 0 map with mirrored core registers
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/100ps
module sfr_map
    import sfr_pkg::*;
#(
    parameter bit HAS_PWR_CTRL = 1'b1, // power control register present
    parameter bit CONV_BIT5 = 1'b1 // converter control bit 5 implemented
) (
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [WB_ADR_W-1:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [WB_DAT_W-1:0] WB_DAT_IN,
    output logic [WB_DAT_W-1:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    input wire logic POWER_ON_RESET_IN,
    input wire logic BROWN_OUT_RESET_IN,
    input wire logic PARITY_ERROR_RESET_IN,
    input wire logic MASTER_CLEAR_PIN_N_IN,
    input wire logic WATCHDOG_RESET_IN,
    input wire logic [PORT_A_W-1:0] PORT_A_PINS_IN,
    input wire logic [DATA_W-1:0] PORT_B_PINS_IN,
    input wire logic CONV_DONE_IN,
    input wire logic [DATA_W-1:0] CONV_RESULT_IN,
    output logic [PC_W-1:0] PC_OUT,
    output logic [2:0] BANK_SELECT_OUT,
    output logic [PORT_A_W-1:0] PORT_A_LATCH_OUT,
    output logic [DATA_W-1:0] PORT_B_LATCH_OUT,
    output logic [DATA_W-1:0] CONV_CONTROL_OUT,
    output logic [1:0] RESET_CLASS_OUT
);
    // ********************************************************
    // bus and reset class
    // ********************************************************
    sfr_access_if acc (); // bus to register bank
    sfr_reset_class_t cls; // current reset class
    logic [RST_SRC_N-1:0] src; // synchronised sources

    sfr_wb_slave u_bus (
        .clk_in(CLK_IN),
        .rst_n_in(RESETN_IN),
        .cyc_in(WB_CYC_IN),
        .stb_in(WB_STB_IN),
        .we_in(WB_WE_IN),
        .adr_in(WB_ADR_IN),
        .sel_in(WB_SEL_IN),
        .dat_in(WB_DAT_IN),
        .dat_out(WB_DAT_OUT),
        .ack_out(WB_ACK_OUT),
        .acc(acc.bus_side)
    );

    sfr_reset_class u_rst (
        .clk_in(CLK_IN),
        .rst_n_in(RESETN_IN),
        .src_in({WATCHDOG_RESET_IN, MASTER_CLEAR_PIN_N_IN, PARITY_ERROR_RESET_IN,
                 BROWN_OUT_RESET_IN, POWER_ON_RESET_IN}),
        .class_out(cls),
        .src_out(src)
    );

    // ********************************************************
    // storage
    // ********************************************************
    logic [DATA_W-1:0] tmr_q, tmr_d; // timer count
    logic [PC_W-1:0] pc_q, pc_d; // program counter
    logic [DATA_W-1:0] status_q, status_d; // core status
    logic [DATA_W-1:0] ptr_q, ptr_d; // indirect pointer
    logic [PORT_A_W-1:0] port_a_q, port_a_d; // port a latch
    logic [DATA_W-1:0] port_b_q, port_b_d; // port b latch
    logic [LATCH_W-1:0] pc_latch_q, pc_latch_d; // holding latch
    logic [DATA_W-1:0] int_ctrl_q, int_ctrl_d; // interrupt control
    logic [DATA_W-1:0] pir_q, pir_d; // peripheral flags
    logic [DATA_W-1:0] conv_res_q, conv_res_d; // conversion result
    logic [DATA_W-1:0] conv_q, conv_d; // converter control
    logic [DATA_W-1:0] pwr_ctrl_q, pwr_ctrl_d; // power control
    logic [PORT_A_W-1:0] pa_s1_q, pa_s2_q; // port a pin synchroniser
    logic [DATA_W-1:0] pb_s1_q, pb_s2_q; // port b pin synchroniser

    // ********************************************************
    // address decode
    // ********************************************************
    // indirect access goes through the pointer; a pointer of zero hits nothing
    wire [IDX_W-1:0] eff = (acc.idx[6:0] == IDX_IND_ACCESS) ? ptr_q : acc.idx;
    wire [6:0] lo = eff[6:0]; // offset within a bank
    wire bank1 = eff[7]; // bank 1 access
    wire mir = (lo == IDX_PC_LOW) | (lo == IDX_STATUS) | (lo == IDX_POINTER) |
               (lo == IDX_PC_LATCH) | (lo == IDX_INT_CTRL); // mirrored core set
    wire vis = mir | ~bank1; // register visible in this bank
    wire s_tmr = vis & (lo == IDX_TMR);
    wire s_pc_low = vis & (lo == IDX_PC_LOW);
    wire s_st = vis & (lo == IDX_STATUS);
    wire s_ptr = vis & (lo == IDX_POINTER);
    wire s_pa = vis & (lo == IDX_PORT_A);
    wire s_pb = vis & (lo == IDX_PORT_B);
    wire s_lat = vis & (lo == IDX_PC_LATCH);
    wire s_int = vis & (lo == IDX_INT_CTRL);
    wire s_pir = vis & (lo == IDX_PIR);
    wire s_adr = vis & (lo == IDX_CONV_RES);
    wire s_cnv = vis & (lo == IDX_CONV);
    wire s_pwr = HAS_PWR_CTRL & (eff == IDX_PWR_CTRL); // absent register decodes nowhere
    wire wr = acc.wr_stb; // write strobe
    wire [DATA_W-1:0] wd = acc.wdata; // write data
    // bit 5 of converter control exists only on some variants
    wire [DATA_W-1:0] conv_mask = CONV_BIT5 ? IMPL_CONV : (IMPL_CONV & ~(8'h01 << CONV_GP));
    wire hw_run = (cls == RC_NONE); // no class reset active

    // ********************************************************
    // read mux, unmapped indices read zero
    // ********************************************************
    assign acc.rdata = s_tmr ? tmr_q :
                       s_pc_low ? pc_q[DATA_W-1:0] :
                       s_st ? status_q :
                       s_ptr ? ptr_q :
                       s_pa ? {3'h0, pa_s2_q} :
                       s_pb ? pb_s2_q :
                       s_lat ? {3'h0, pc_latch_q} :
                       s_int ? int_ctrl_q :
                       s_pir ? pir_q :
                       s_adr ? conv_res_q :
                       s_cnv ? conv_q :
                       s_pwr ? pwr_ctrl_q : RV_ZERO;

    // ********************************************************
    // next state per reset class
    // ********************************************************
    always_comb begin
        tmr_d = tmr_q;
        pc_d = pc_q;
        status_d = status_q;
        ptr_d = ptr_q;
        port_a_d = port_a_q;
        port_b_d = port_b_q;
        pc_latch_d = pc_latch_q;
        int_ctrl_d = int_ctrl_q;
        pir_d = pir_q;
        conv_res_d = conv_res_q;
        conv_d = conv_q;
        pwr_ctrl_d = pwr_ctrl_q;
        unique case (cls)
            RC_POWER: begin
                // unknown bits come up as zero
                tmr_d = RV_ZERO;
                pc_d = '0;
                status_d = RV_STATUS;
                ptr_d = RV_ZERO;
                port_a_d = '0;
                port_b_d = RV_ZERO;
                pc_latch_d = '0;
                int_ctrl_d = RV_ZERO;
                pir_d = RV_ZERO;
                conv_res_d = RV_ZERO;
                conv_d = RV_ZERO;
                // cause bits go low for the source that fired, top bit kept
                pwr_ctrl_d = {pwr_ctrl_q[7], RV_PWR_CTRL[6:3], ~src[SRC_PARITY], ~src[SRC_POR], ~src[SRC_BROWN]};
            end
            RC_OTHER: begin
                // timer, pointer, port b, result keep their contents
                pc_d = '0;
                // time-out low only for watchdog, power-down stays set
                status_d = {3'b000, ~src[SRC_WDT], 1'b1, status_q[2:0] & KEEP_STATUS[2:0]};
                // port a top latch bit survives, the rest clear
                port_a_d = {port_a_q[PORT_A_W-1], {(PORT_A_W-1){1'b0}}};
                pc_latch_d = '0;
                int_ctrl_d = int_ctrl_q & KEEP_INT_CTRL;
                pir_d = RV_ZERO;
                conv_d = RV_ZERO;
            end
            RC_NONE: begin
                if (wr & s_tmr) tmr_d = wd;
                // counter low write pulls the upper bits from the latch
                if (wr & s_pc_low) pc_d = {pc_latch_q, wd};
                if (wr & s_st) status_d = (status_q & ~WM_STATUS) | (wd & WM_STATUS);
                if (wr & s_ptr) ptr_d = wd;
                if (wr & s_pa) port_a_d = wd[PORT_A_W-1:0];
                if (wr & s_pb) port_b_d = wd;
                if (wr & s_lat) pc_latch_d = wd[LATCH_W-1:0]; // upper bits dropped
                if (wr & s_int) int_ctrl_d = wd;
                if (wr & s_pir) pir_d = wd & (8'h01 << PIR_CONV);
                if (wr & s_adr) conv_res_d = wd;
                if (wr & s_cnv) conv_d = wd & conv_mask;
                if (wr & s_pwr) pwr_ctrl_d = (pwr_ctrl_q & ~WM_PWR_CTRL) | (wd & WM_PWR_CTRL);
                // conversion end: result loads, run bit clears, flag set wins
                if (CONV_DONE_IN) begin
                    conv_res_d = CONV_RESULT_IN;
                    conv_d[CONV_GO] = 1'b0;
                    pir_d[PIR_CONV] = 1'b1;
                end
            end
        endcase
    end

    // ********************************************************
    // registers
    // ********************************************************
    // async reset counts as a power-up, unknowns forced to zero
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            tmr_q <= RV_ZERO;
            pc_q <= '0;
            status_q <= RV_STATUS;
            ptr_q <= RV_ZERO;
            port_a_q <= '0;
            port_b_q <= RV_ZERO;
            pc_latch_q <= '0;
            int_ctrl_q <= RV_ZERO;
            pir_q <= RV_ZERO;
            conv_res_q <= RV_ZERO;
            conv_q <= RV_ZERO;
            pwr_ctrl_q <= RV_PWR_CTRL;
        end else begin
            tmr_q <= tmr_d;
            pc_q <= pc_d;
            status_q <= status_d;
            ptr_q <= ptr_d;
            port_a_q <= port_a_d;
            port_b_q <= port_b_d;
            pc_latch_q <= pc_latch_d;
            int_ctrl_q <= int_ctrl_d;
            pir_q <= pir_d;
            conv_res_q <= conv_res_d;
            conv_q <= conv_d;
            pwr_ctrl_q <= pwr_ctrl_d;
        end
    end

    // pin inputs cross two flops before the read mux sees them
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            pa_s1_q <= '0;
            pa_s2_q <= '0;
            pb_s1_q <= '0;
            pb_s2_q <= '0;
        end else begin
            pa_s1_q <= PORT_A_PINS_IN;
            pa_s2_q <= pa_s1_q;
            pb_s1_q <= PORT_B_PINS_IN;
            pb_s2_q <= pb_s1_q;
        end
    end

    // ********************************************************
    // outputs
    // ********************************************************
    assign PC_OUT = pc_q;
    // passed as stored; the core keeps the reserved pair clear
    assign BANK_SELECT_OUT = status_q[7:5];
    assign PORT_A_LATCH_OUT = port_a_q;
    assign PORT_B_LATCH_OUT = port_b_q;
    assign CONV_CONTROL_OUT = conv_q;
    assign RESET_CLASS_OUT = cls;

    // ********************************************************
    // checks
    // ********************************************************
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RESETN_IN);
    wire rd_req = WB_CYC_IN & WB_STB_IN & ~WB_WE_IN & ~WB_ACK_OUT; // read request edge
    wire unmapped = ~(s_tmr | s_pc_low | s_st | s_ptr | s_pa | s_pb | s_lat | s_int |
                      s_pir | s_adr | s_cnv | s_pwr);

    property p_unmapped_zero;
        rd_req & unmapped |=> WB_ACK_OUT && (WB_DAT_OUT == '0);
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

    property p_power_values;
        cls == RC_POWER |=> status_q == RV_STATUS && pc_latch_q == '0 && conv_q == RV_ZERO;
    endproperty
    a_power_values: assert property (p_power_values) else $error("power-up values wrong");

    property p_other_keeps;
        cls == RC_OTHER |=> tmr_q == $past(tmr_q) && ptr_q == $past(ptr_q) && int_ctrl_q[0] == $past(int_ctrl_q[0]);
    endproperty
    a_other_keeps: assert property (p_other_keeps) else $error("other reset lost a kept bit");

    property p_wdt_timeout;
        cls == RC_OTHER && src[SRC_WDT] |=> !status_q[ST_TO] && status_q[ST_PD];
    endproperty
    a_wdt_timeout: assert property (p_wdt_timeout) else $error("time-out flag not cleared");

    property p_pc_load;
        hw_run && wr && s_pc_low |=> pc_q == {$past(pc_latch_q), $past(wd)};
    endproperty
    a_pc_load: assert property (p_pc_load) else $error("counter upper bits not from latch");

    property p_mirror;
        hw_run && wr && acc.idx == {1'b1, IDX_STATUS} |=> status_q[2:0] == $past(wd[2:0]);
    endproperty
    a_mirror: assert property (p_mirror) else $error("bank 1 status write missed");

    property p_no_pwr_ctrl;
        eff == IDX_PWR_CTRL |-> acc.rdata == (HAS_PWR_CTRL ? pwr_ctrl_q : RV_ZERO);
    endproperty
    a_no_pwr_ctrl: assert property (p_no_pwr_ctrl) else $error("power control read wrong");

    property p_bit5;
        hw_run && wr && s_cnv && !CONV_DONE_IN |=> conv_q[CONV_GP] == (CONV_BIT5 & $past(wd[CONV_GP])) && !conv_q[1];
    endproperty
    a_bit5: assert property (p_bit5) else $error("converter bit 5 wrong");

    property p_write_edge;
        hw_run && wr && s_lat |=> pc_latch_q == $past(wd[LATCH_W-1:0]) ##1 !WB_ACK_OUT;
    endproperty
    a_write_edge: assert property (p_write_edge) else $error("latch write or ack drop wrong");
endmodule : sfr_map

//--- tb/sfr_core_model.sv
// processor core model issuing wishbone data memory accesses
`timescale 1ns/100ps
module sfr_core_model (
    input wire logic clk_in,
    input wire logic ack_in,
    output logic cyc_out,
    output logic stb_out,
    output logic we_out,
    output logic [9:0] adr_out,
    output logic [3:0] sel_out,
    output logic [31:0] dat_out
);
    // bus idle at time zero
    initial begin
        {cyc_out, stb_out, we_out, adr_out, sel_out, dat_out} = '0;
    end
    // one classic cycle, held until ack is sampled high
    task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk_in);
        cyc_out <= 1'b1;
        stb_out <= 1'b1;
        we_out <= w;
        adr_out <= {idx, 2'b00};
        sel_out <= 4'hf;
        // software keeps the reserved bank select bits clear
        dat_out <= {24'h0, (idx[6:0] == 7'h03) ? (d & 8'h3f) : d};
        do @(posedge clk_in); while (ack_in !== 1'b1);
        cyc_out <= 1'b0;
        stb_out <= 1'b0;
        we_out <= 1'b0;
        // released data must not look like the last value
        dat_out <= ~dat_out;
        @(posedge clk_in);
    endtask : acc
endmodule : sfr_core_model

//--- tb/special_function_register_map_tb_top.sv
// self-checking bench for the special function register map
`timescale 1ns/100ps
module special_function_register_map_tb_top;
    import sfr_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, por = 1'b0, wdt = 1'b0, cyc, stb, we, ack;
    logic [9:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [12:0] pc;
    logic [1:0] rcls;
    logic [2:0] bsel;
    logic [7:0] pb = 8'h00, t, p, pbl, ccl;
    logic [4:0] pa = 5'h00, pal;
    logic [15:0] lf = 16'd52532; // random seed
    logic [7:0] expq[$]; // expected read data, oldest first
    int err_total = 0, cmp_count = 0, cyc_n = 0;
    always #20 clk = ~clk;
    sfr_map DUT (.CLK_IN(clk), .RESETN_IN(rstn), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
        .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
        .POWER_ON_RESET_IN(por), .BROWN_OUT_RESET_IN(1'b0), .PARITY_ERROR_RESET_IN(1'b0),
        .MASTER_CLEAR_PIN_N_IN(1'b1), .WATCHDOG_RESET_IN(wdt), .PORT_A_PINS_IN(pa), .PORT_B_PINS_IN(pb),
        .CONV_DONE_IN(1'b0), .CONV_RESULT_IN(8'h00), .PC_OUT(pc), .BANK_SELECT_OUT(bsel), .PORT_A_LATCH_OUT(pal),
        .PORT_B_LATCH_OUT(pbl), .CONV_CONTROL_OUT(ccl), .RESET_CLASS_OUT(rcls));
    sfr_core_model core (.clk_in(clk), .ack_in(ack), .cyc_out(cyc), .stb_out(stb), .we_out(we),
        .adr_out(adr), .sel_out(sel), .dat_out(wdat));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("mismatches %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        expq.push_back(e);
        core.acc(1'b0, idx, 8'h00);
    endtask : rd
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        core.acc(1'b1, idx, d);
    endtask : wr
    // hold one reset source pin, check its class, then let it settle
    task automatic pin(input bit w, input logic [1:0] c);
        wdt <= w;
        por <= !w;
        repeat (6) @(posedge clk);
        chk({30'h0, rcls}, {30'h0, c});
        wdt <= 1'b0;
        por <= 1'b0;
        repeat (6) @(posedge clk);
    endtask : pin
    // read data is compared at the ack edge; a hang ends the run
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0) begin
            chk(rdat, {24'h0, expq.pop_front()});
        end
        cyc_n++;
        if (cyc_n == 4000) begin
            err_total++;
            close_out();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        pa <= 5'h15;
        pb <= 8'ha6;
        rd(8'h03, RV_STATUS);
        rd(8'h8e, RV_PWR_CTRL);
        rd(8'h06, 8'ha6);
        rd(8'h05, 8'h15);
        // every hole of bank 0 from 0x07 to 0x1d ignores writes and reads zero
        for (int i = 7; i < 30; i++) begin
            if (i < 10 || i > 12) begin
                wr(i[7:0], 8'hff);
                rd(i[7:0], 8'h00);
            end
        end
        lf = lfsr(lf);
        t = lf[7:0];
        lf = lfsr(lf);
        p = lf[7:0];
        wr(8'h01, t);
        wr(8'h84, p);
        rd(8'h04, p);
        wr(8'h83, 8'hff);
        rd(8'h03, 8'h3f);
        chk({29'h0, bsel}, 32'h1);
        wr(8'h1f, 8'hff);
        rd(8'h1f, IMPL_CONV);
        chk({24'h0, ccl}, {24'h0, IMPL_CONV});
        wr(8'h8a, 8'hff);
        rd(8'h0a, 8'h1f);
        wr(8'h02, 8'h34);
        chk({19'h0, pc}, 32'h00001f34);
        wr(8'h05, 8'h1f);
        wr(8'h06, p);
        pin(1'b1, 2'b01);
        chk({19'h0, pc}, 32'h0);
        chk({27'h0, pal}, 32'h10);
        chk({24'h0, pbl}, {24'h0, p});
        chk({24'h0, ccl}, 32'h0);
        rd(8'h01, t);
        rd(8'h04, p);
        rd(8'h03, 8'h0f);
        rd(8'h0a, 8'h00);
        rd(8'h1f, 8'h00);
        rd(8'h8e, RV_PWR_CTRL);
        pin(1'b0, 2'b11);
        chk({27'h0, pal}, 32'h0);
        chk({24'h0, pbl}, 32'h0);
        rd(8'h01, 8'h00);
        rd(8'h03, RV_STATUS);
        rd(8'h8e, 8'h05);
        close_out();
    end
endmodule : special_function_register_map_tb_top
